// ==== rtl/ldr_pkg.sv ====
// Constants for the dimming register bank of channels nine to eleven
package ldr_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CODE_W = 6;
   localparam int LOW_W = 4;
   localparam int HIGH_W = 8;
   localparam int DUTY_W = 12;
   localparam int LEVEL_W = 8;
   localparam int PROD_W = 14;

   // Register offsets
   localparam logic [7:0] CHAN9_CURRENT_CODE = 8'h22;
   localparam logic [7:0] CHAN9_DUTY_LOW = 8'h23;
   localparam logic [7:0] CHAN9_DUTY_HIGH = 8'h24;
   localparam logic [7:0] CHAN10_CURRENT_CODE = 8'h25;
   localparam logic [7:0] CHAN10_DUTY_LOW = 8'h26;
   localparam logic [7:0] CHAN10_DUTY_HIGH = 8'h27;
   localparam logic [7:0] CHAN11_CURRENT_CODE = 8'h28;
   localparam logic [7:0] CHAN11_DUTY_LOW = 8'h29;
   localparam logic [7:0] CHAN11_DUTY_HIGH = 8'h2a;

   // Field positions
   localparam int CODE_MSB = 5;
   localparam int LOW_MSB = 3;
   localparam int HIGH_MSB = 7;

   // Reset values
   localparam logic [5:0] CODE_RST = 6'h3f;
   localparam logic [3:0] LOW_RST = 4'hf;
   localparam logic [7:0] HIGH_RST = 8'hff;

   // Current scaling: level = code * full scale / code maximum
   localparam logic [13:0] CODE_MAX = 14'h003f;
   localparam logic [13:0] LEVEL_FULL = 14'h00ff;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
endpackage

// ==== rtl/ldr_chan.sv ====
// One channel: analog code, pending low nibble and applied duty value
module ldr_chan
   import ldr_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic wr_code,
   input wire logic wr_low,
   input wire logic wr_high,
   input wire logic [7:0] wdata,
   output logic [5:0] analog_code,
   output logic [3:0] low_pending,
   output logic [11:0] duty_value,
   output logic [7:0] sink_current
);
   logic [13:0] code_product;
   logic [7:0] next_sink_current;

   // R2 - current scales by code over 63
   assign code_product = PROD_W'(analog_code) * LEVEL_FULL;
   assign next_sink_current = LEVEL_W'(code_product / CODE_MAX);

   always_ff @(posedge clk) begin
      if (srst) begin
         analog_code <= CODE_RST;
         low_pending <= LOW_RST;
         duty_value <= {HIGH_RST, LOW_RST};
         sink_current <= LEVEL_W'(LEVEL_FULL);
      end else begin
         // R1 - code stored from bits 5:0
         // R8 - upper bits are dropped
         if (wr_code) begin
            analog_code <= wdata[CODE_MSB:0];
         end
         // R3 - low nibble held pending
         if (wr_low) begin
            low_pending <= wdata[LOW_MSB:0];
         end
         // R5 - duty applied on high write
         // R4 - high byte fills duty 11:4
         if (wr_high) begin
            duty_value <= {wdata[HIGH_MSB:0], low_pending};
         end
         sink_current <= next_sink_current;
      end
   end
endmodule

// ==== rtl/ldr_dimming_regs.sv ====
// Dimming register bank for channels nine to eleven
// Functional notes
// R1 - Analog code is bits 5:0 of current register, read/write, resets to 63.
// R2 - Sink current level is analog code over 63 times full scale.
// R3 - Low duty register bits 3:0 read/write, reset ones; bits 7:4 read zero.
// R4 - High duty register holds duty bits 11:4, read/write, resets to ones.
// R5 - Low nibble waits; full duty applies only when high byte written.
// R6 - Code, low, high at consecutive addresses from 0x22, 0x25, 0x28.
// R7 - Current register bits 7:6 always read zero.
// R8 - Writes to reserved bits are ignored silently.
module ldr_dimming_regs
   import ldr_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic [5:0] chan9_analog_code,
   output logic [5:0] chan10_analog_code,
   output logic [5:0] chan11_analog_code,
   output logic [11:0] chan9_duty_value,
   output logic [11:0] chan10_duty_value,
   output logic [11:0] chan11_duty_value,
   output logic [7:0] chan9_sink_current,
   output logic [7:0] chan10_sink_current,
   output logic [7:0] chan11_sink_current
);
   logic hit9_code, hit9_low, hit9_high;
   logic hit10_code, hit10_low, hit10_high;
   logic hit11_code, hit11_low, hit11_high;
   logic [3:0] low9, low10, low11;
   logic [7:0] rd_mux;
   logic any_hit;

   // R6 - address decode per channel
   assign hit9_code = (reg_addr == CHAN9_CURRENT_CODE);
   assign hit9_low = (reg_addr == CHAN9_DUTY_LOW);
   assign hit9_high = (reg_addr == CHAN9_DUTY_HIGH);
   assign hit10_code = (reg_addr == CHAN10_CURRENT_CODE);
   assign hit10_low = (reg_addr == CHAN10_DUTY_LOW);
   assign hit10_high = (reg_addr == CHAN10_DUTY_HIGH);
   assign hit11_code = (reg_addr == CHAN11_CURRENT_CODE);
   assign hit11_low = (reg_addr == CHAN11_DUTY_LOW);
   assign hit11_high = (reg_addr == CHAN11_DUTY_HIGH);
   assign any_hit = hit9_code || hit9_low || hit9_high || hit10_code
      || hit10_low || hit10_high || hit11_code || hit11_low || hit11_high;

   ldr_chan u_chan9 (
      .clk(clk),
      .srst(srst),
      .wr_code(reg_wr && hit9_code),
      .wr_low(reg_wr && hit9_low),
      .wr_high(reg_wr && hit9_high),
      .wdata(reg_wdata),
      .analog_code(chan9_analog_code),
      .low_pending(low9),
      .duty_value(chan9_duty_value),
      .sink_current(chan9_sink_current)
   );

   ldr_chan u_chan10 (
      .clk(clk),
      .srst(srst),
      .wr_code(reg_wr && hit10_code),
      .wr_low(reg_wr && hit10_low),
      .wr_high(reg_wr && hit10_high),
      .wdata(reg_wdata),
      .analog_code(chan10_analog_code),
      .low_pending(low10),
      .duty_value(chan10_duty_value),
      .sink_current(chan10_sink_current)
   );

   ldr_chan u_chan11 (
      .clk(clk),
      .srst(srst),
      .wr_code(reg_wr && hit11_code),
      .wr_low(reg_wr && hit11_low),
      .wr_high(reg_wr && hit11_high),
      .wdata(reg_wdata),
      .analog_code(chan11_analog_code),
      .low_pending(low11),
      .duty_value(chan11_duty_value),
      .sink_current(chan11_sink_current)
   );

   // R7 - reserved code bits read zero
   // R3 - low register upper nibble reads zero
   assign rd_mux =
      hit9_code ? {2'b00, chan9_analog_code} :
      hit9_low ? {4'h0, low9} :
      hit9_high ? chan9_duty_value[11:4] :
      hit10_code ? {2'b00, chan10_analog_code} :
      hit10_low ? {4'h0, low10} :
      hit10_high ? chan10_duty_value[11:4] :
      hit11_code ? {2'b00, chan11_analog_code} :
      hit11_low ? {4'h0, low11} :
      hit11_high ? chan11_duty_value[11:4] :
      UNMAPPED_DATA;

   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_mux;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   code_reset_a: // R1
      assert property (@(posedge clk) disable iff (1'b0)
         srst |=> chan9_analog_code == CODE_RST
            && chan11_analog_code == CODE_RST)
      else $error("analog code not at reset value");

   code_write_a: // R1
      assert property (reg_wr && hit10_code
         |=> chan10_analog_code == $past(reg_wdata[5:0]))
      else $error("analog code write lost");

   current_scale_a: // R2
      assert property (##1 chan9_sink_current ==
         LEVEL_W'((PROD_W'($past(chan9_analog_code)) * LEVEL_FULL)
            / CODE_MAX))
      else $error("sink current not code over 63");

   low_read_a: // R3
      assert property (reg_rd && hit11_low
         |=> reg_rvalid && reg_rdata[7:4] == 4'h0
            && reg_rdata[3:0] == $past(low11))
      else $error("low duty readback wrong");

   duty_apply_a: // R4
      assert property (reg_wr && hit9_high
         |=> chan9_duty_value == {$past(reg_wdata), $past(low9)})
      else $error("duty not applied on high write");

   low_hold_a: // R5
      assert property (reg_wr && hit10_low
         |=> $stable(chan10_duty_value) && low10 == $past(reg_wdata[3:0]))
      else $error("low write changed duty early");

   bank_place_a: // R6
      assert property (reg_wr && hit11_code
         |=> $stable(chan9_analog_code) && $stable(chan10_analog_code)
            && chan11_analog_code == $past(reg_wdata[5:0]))
      else $error("write reached wrong channel");

   rvalid_pulse_a: // R6
      assert property (##1 reg_rvalid == $past(reg_rd))
      else $error("read valid not one cycle after read");

   rdata_hold_a: // R6
      assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   unmapped_read_a: // R6
      assert property (reg_rd && !any_hit |=> reg_rdata == UNMAPPED_DATA)
      else $error("unmapped read not zero");

   code_read_a: // R1
      assert property (reg_rd && hit10_code
         |=> reg_rdata == {2'b00, $past(chan10_analog_code)})
      else $error("analog code readback wrong");

   high_read_a: // R4
      assert property (reg_rd && hit9_high
         |=> reg_rdata == $past(chan9_duty_value[11:4]))
      else $error("high duty readback wrong");

   duty_reset_a: // R4
      assert property (@(posedge clk) disable iff (1'b0)
         srst |=> chan9_duty_value == {HIGH_RST, LOW_RST}
            && chan10_duty_value == {HIGH_RST, LOW_RST}
            && chan11_duty_value == {HIGH_RST, LOW_RST})
      else $error("duty not at reset value");

   low_reset_a: // R3
      assert property (@(posedge clk) disable iff (1'b0)
         srst |=> low9 == LOW_RST && low10 == LOW_RST
            && low11 == LOW_RST)
      else $error("low nibble not at reset value");

   low_pending_a: // R5
      assert property (reg_wr && hit9_low
         |=> low9 == $past(reg_wdata[3:0]) && $stable(chan9_duty_value))
      else $error("low nibble not held pending");

   high_apply_a: // R5
      assert property (reg_wr && hit11_high
         |=> chan11_duty_value == {$past(reg_wdata), $past(low11)})
      else $error("duty not applied on high write");

   current_off_a: // R2
      assert property (chan10_analog_code == 6'h00
         |=> chan10_sink_current == 8'h00)
      else $error("code zero still drives current");

   current_full_a: // R2
      assert property (chan10_analog_code == CODE_RST
         |=> chan10_sink_current == LEVEL_W'(LEVEL_FULL))
      else $error("full code not full current");

   reserved_read_a: // R7
      assert property (reg_rd && (hit9_code || hit10_code || hit11_code)
         |=> reg_rdata[7:6] == 2'b00)
      else $error("reserved code bits not zero");

   unmapped_write_a: // R8
      assert property (reg_wr && rd_mux == UNMAPPED_DATA
         && !(hit9_code || hit9_low || hit9_high || hit10_code
            || hit10_low || hit10_high || hit11_code || hit11_low
            || hit11_high)
         |=> $stable(chan9_duty_value) && $stable(chan10_duty_value)
            && $stable(chan11_duty_value))
      else $error("unmapped write changed state");

   low_then_high_c: cover property (
      reg_wr && hit9_low ##1 reg_wr && hit9_high);
   code_zero_c: cover property (
      reg_wr && hit10_code && reg_wdata[5:0] == 6'h00);
   reserved_write_c: cover property (
      reg_wr && hit11_code && reg_wdata[7:6] != 2'b00);
   readback_c: cover property (reg_rd && hit10_high ##1 reg_rvalid);
   unmapped_write_c: cover property (reg_wr && !any_hit);
endmodule

// ==== testbench/ldr_host.sv ====
// Host model driving the register strobes of the dimming bank
module ldr_host (
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Released lines show the inverted last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(posedge clk);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
      v = reg_rvalid;
   endtask
endmodule

// ==== testbench/ldr_dimming_regs_bench.sv ====
// Self-checking bench for the dimming register bank
module ldr_dimming_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import ldr_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic reg_wr, reg_rd, reg_rvalid, rd_valid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_data, base;
   logic [5:0] code [3];
   logic [11:0] duty [3];
   logic [7:0] cur [3];
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   ldr_host i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   ldr_dimming_regs i_dut (.clk(clk), .srst(srst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .chan9_analog_code(code[0]), .chan10_analog_code(code[1]),
      .chan11_analog_code(code[2]), .chan9_duty_value(duty[0]),
      .chan10_duty_value(duty[1]), .chan11_duty_value(duty[2]),
      .chan9_sink_current(cur[0]), .chan10_sink_current(cur[1]),
      .chan11_sink_current(cur[2]));
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         $display("BAD %0t got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      i_host.rd(a, rd_data, rd_valid);
      chk({11'h000, rd_valid}, 12'h001);
      chk({4'h0, rd_data}, {4'h0, exp});
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      #1;
      srst = 1'b0;
      for (int c = 0; c < 3; c++) begin
         base = 8'h22 + 8'(3 * c);
         rchk(base, 8'h3f);
         rchk(base + 8'h01, 8'h0f);
         rchk(base + 8'h02, 8'hff);
         chk(duty[c], 12'hfff);
         chk({4'h0, cur[c]}, 12'h0ff);
         i_host.wr(base, 8'hc5);
         rchk(base, 8'h05);
         chk({6'h00, code[c]}, 12'h005);
         chk({4'h0, cur[c]}, 12'h014);
         i_host.wr(base + 8'h01, 8'hf6);
         rchk(base + 8'h01, 8'h06);
         chk(duty[c], 12'hfff);
         i_host.wr(base + 8'h02, 8'h9c);
         rchk(base + 8'h02, 8'h9c);
         chk(duty[c], 12'h9c6);
      end
      i_host.wr(8'h25, 8'hc0);
      rchk(8'h25, 8'h00);
      chk({4'h0, cur[1]}, 12'h000);
      i_host.wr(8'h27, 8'h12);
      chk(duty[1], 12'h126);
      rchk(8'h27, 8'h12);
      i_host.wr(8'h2b, 8'h55);
      chk(duty[0], 12'h9c6);
      chk(duty[1], 12'h126);
      chk(duty[2], 12'h9c6);
      chk({6'h00, code[2]}, 12'h005);
      rchk(8'h21, 8'h00);
      rchk(8'h2b, 8'h00);
      @(posedge clk);
      #1;
      srst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      srst = 1'b0;
      for (int c = 0; c < 3; c++) begin
         chk({6'h00, code[c]}, {6'h00, CODE_RST});
         chk(duty[c], {HIGH_RST, LOW_RST});
         chk({4'h0, cur[c]}, 12'h0ff);
         rchk(CHAN9_CURRENT_CODE + 8'(3 * c), 8'h3f);
         rchk(CHAN9_DUTY_LOW + 8'(3 * c), 8'h0f);
      end
      print_verdict();
   end
endmodule
